/* File: hw/clock_control_defines.vh */
// Constants for the core clock, loop ratio and reset release block
`ifndef CLOCK_CONTROL_DEFINES_VH
`define CLOCK_CONTROL_DEFINES_VH

`define ADDR_PMC          12'h000
`define ADDR_SPI_BAUD     12'h004
`define ADDR_STATUS       12'h008
`define ADDR_VCO_RATIO    12'h00C
`define ADDR_SPORT_BASE   12'h010

`define PMC_MULT_LSB      0
`define PMC_MULT_W        6
`define PMC_DIV_LSB       6
`define PMC_DIV_W         2
`define PMC_HALVE_BIT     8

`define STRAP_MULT_00     6'h06
`define STRAP_MULT_01     6'h10
`define STRAP_MULT_10     6'h08
`define STRAP_MULT_11     6'h06

`define PMC_DIV_RESET     2'h0
`define PMC_HALVE_RESET   1'h0
`define SPI_BAUD_RESET    16'h0004
`define SPORT_DIV_RESET   16'h0004

`define CORE_RELEASE_CYCLES 4096
`define MEM_PER_CORE      2'h2

`endif

/* File: hw/core_clock_pll_reset_control.v */
// Core clock ratio control, derived clock enables and core reset release
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "clock_control_defines.vh"

module core_clock_pll_reset_control #(
    parameter NUM_SPORTS     = 2,
    parameter RELEASE_CYCLES = `CORE_RELEASE_CYCLES
) (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [11:0]             paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output wire                    pslverr,
    input  wire                    reset_in_n,
    input  wire [1:0]              ratio_select_pins,
    input  wire                    core_tick,
    output reg                     core_reset_n,
    output reg  [7:0]              vco_mult,
    output reg  [7:0]              core_div,
    output reg  [1:0]              mem_per_core,
    output reg  [NUM_SPORTS-1:0]   sport_tick,
    output reg                     spi_tick
);

    localparam ST_HOLD    = 2'h0;
    localparam ST_COUNT   = 2'h1;
    localparam ST_RUN     = 2'h2;

    // Last value of the release counter; it counts 0..REL_LAST while in ST_COUNT
    localparam [12:0] REL_LAST = RELEASE_CYCLES - 1;

    // Strap decode, used for the reset-time multiplier and for the handover at release
    function [5:0] strap_mult;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    strap_mult = `STRAP_MULT_00;
                2'h1:    strap_mult = `STRAP_MULT_01;
                2'h2:    strap_mult = `STRAP_MULT_10;
                default: strap_mult = `STRAP_MULT_11;
            endcase
        end
    endfunction

    // Field 0..3 selects 2, 4, 8, 16
    function [4:0] post_div_value;
        input [1:0] code;
        begin
            post_div_value = 5'h02 << code;
        end
    endfunction

    // A ratio of zero is taken as one so a divider never stalls
    function [15:0] safe_ratio;
        input [15:0] r;
        begin
            safe_ratio = (r == 16'h0000) ? 16'h0001 : r;
        end
    endfunction

    reg [1:0]  rst_sync_ff;
    reg [1:0]  strap_meta_ff;
    reg [1:0]  strap_ff;
    reg [1:0]  state_ff;
    reg [1:0]  nxt_state;
    reg [12:0] rel_cnt_ff;
    reg [12:0] nxt_rel_cnt;
    reg [5:0]  mult_ff;
    reg [1:0]  div_code_ff;
    reg        halve_ff;
    reg [15:0] spi_baud_ff;
    reg [15:0] spi_cnt_ff;
    reg [15:0] sport_div_ff [0:NUM_SPORTS-1];
    reg [15:0] sport_cnt_ff [0:NUM_SPORTS-1];
    reg [5:0]  eff_mult;
    reg [4:0]  eff_div;
    reg        addr_ok;
    reg [31:0] rd_mux;
    // Loop variables, one per process so no two processes drive the same one
    integer    i;
    integer    j;
    integer    k;

    // Core is held in reset in both the wait and the count states
    wire in_reset = (state_ff != ST_RUN);
    wire wr_en    = psel & penable & pwrite;
    wire rd_en    = psel & penable & ~pwrite;
    // Register hits shared by the write paths
    wire pmc_hit  = (paddr == `ADDR_PMC);
    wire spi_hit  = (paddr == `ADDR_SPI_BAUD);
    // Setup phase of a read: the read word is captured here and stands through access
    wire rd_setup = psel & ~penable & ~pwrite;
    wire sport_hit = (paddr >= `ADDR_SPORT_BASE) &&
                     (paddr < `ADDR_SPORT_BASE + NUM_SPORTS * 4) && (paddr[1:0] == 2'h0);
    wire [11:0] sport_off = paddr - `ADDR_SPORT_BASE;
    wire [11:0] sport_idx = {2'h0, sport_off[11:2]};

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    // Reset pin comes from outside: two flops before any use. A pin that misses
    // its setup window only moves the release one edge later.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], reset_in_n};
        end
    end

    // Strap pins are static in use but still pass two flops, so a pin that
    // moves during reset never feeds a half-settled value to the decode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_meta_ff <= 2'h0;
            strap_ff      <= 2'h0;
        end else begin
            strap_meta_ff <= ratio_select_pins;
            strap_ff      <= strap_meta_ff;
        end
    end

    // Release sequencer on the input clock. The pin takes two edges to sync,
    // one more to enter ST_COUNT, then RELEASE_CYCLES edges to reach ST_RUN.
    // A drop of the synced pin in any state restarts the whole sequence.
    always @* begin
        nxt_state   = state_ff;
        nxt_rel_cnt = rel_cnt_ff;
        case (state_ff)
            ST_HOLD: begin
                nxt_rel_cnt = 13'h0000;
                if (rst_sync_ff[1]) begin
                    nxt_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!rst_sync_ff[1]) begin
                    nxt_state = ST_HOLD;
                end else if (rel_cnt_ff == REL_LAST) begin
                    nxt_state = ST_RUN;
                end else begin
                    nxt_rel_cnt = rel_cnt_ff + 13'h0001;
                end
            end
            ST_RUN: begin
                if (!rst_sync_ff[1]) begin
                    nxt_state = ST_HOLD;
                end
            end
            default: nxt_state = ST_HOLD;
        endcase
    end

    // core_reset_n comes from the next state so it moves together with state_ff
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff     <= ST_HOLD;
            rel_cnt_ff   <= 13'h0000;
            core_reset_n <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            rel_cnt_ff   <= nxt_rel_cnt;
            core_reset_n <= (nxt_state == ST_RUN);
        end
    end

    // Effective loop settings: straps rule while in reset. Writes to the loop
    // fields are refused then, so the strapped multiplier is what the core wakes with.
    always @* begin
        if (in_reset) begin
            eff_mult = strap_mult(strap_ff);
            eff_div  = 5'h01;
        end else begin
            eff_mult = mult_ff;
            eff_div  = post_div_value(div_code_ff);
        end
    end

    // Core/input = vco_mult / core_div; halving doubles the divisor
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_mult <= 8'h00;
            core_div <= 8'h00;
        end else begin
            vco_mult <= {1'b0, eff_mult, 1'b0};
            // Halving is never applied in reset, where the post divider is 1
            core_div <= {2'h0, eff_div, 1'b0} << (halve_ff & ~in_reset);
        end
    end

    // Memory clocks per core clock; the memory clock runs at twice the core rate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_per_core <= 2'h0;
        end else begin
            mem_per_core <= `MEM_PER_CORE;
        end
    end

    // Software loop fields; at release they inherit the strapped multiplier
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_ff     <= `STRAP_MULT_00;
            div_code_ff <= `PMC_DIV_RESET;
            halve_ff    <= `PMC_HALVE_RESET;
        end else if (in_reset) begin
            mult_ff     <= strap_mult(strap_ff);
            div_code_ff <= `PMC_DIV_RESET;
            halve_ff    <= `PMC_HALVE_RESET;
        end else if (wr_en && pmc_hit) begin
            // Range limits on the result are software's to respect; a bad
            // multiplier is stored as written and not clamped
            mult_ff     <= pwdata[`PMC_MULT_LSB +: `PMC_MULT_W];
            div_code_ff <= pwdata[`PMC_DIV_LSB +: `PMC_DIV_W];
            halve_ff    <= pwdata[`PMC_HALVE_BIT];
        end
    end

    // SPI ratio register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spi_baud_ff <= `SPI_BAUD_RESET;
        end else if (wr_en && spi_hit) begin
            spi_baud_ff <= pwdata[15:0];
        end
    end

    // Serial port ratio registers, one aligned word per port above the base
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (j = 0; j < NUM_SPORTS; j = j + 1) begin
                sport_div_ff[j] <= `SPORT_DIV_RESET;
            end
        end else if (wr_en && sport_hit) begin
            for (j = 0; j < NUM_SPORTS; j = j + 1) begin
                if (sport_idx == j[11:0]) begin
                    sport_div_ff[j] <= pwdata[15:0];
                end
            end
        end
    end

    // SPI clock enable: one tick per ratio core ticks, held while core is in reset.
    // Counters clear in reset so the first tick after release comes a full period on.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spi_cnt_ff <= 16'h0000;
            spi_tick   <= 1'b0;
        end else if (in_reset) begin
            spi_cnt_ff <= 16'h0000;
            spi_tick   <= 1'b0;
        end else begin
            spi_tick <= 1'b0;
            if (core_tick) begin
                if (spi_cnt_ff >= safe_ratio(spi_baud_ff) - 16'h0001) begin
                    spi_cnt_ff <= 16'h0000;
                    spi_tick   <= 1'b1;
                end else begin
                    spi_cnt_ff <= spi_cnt_ff + 16'h0001;
                end
            end
        end
    end

    // Serial port enables; the >= compare lets a ratio lowered mid-count wrap at
    // once instead of running the counter round through its full range
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sport_tick <= {NUM_SPORTS{1'b0}};
            for (k = 0; k < NUM_SPORTS; k = k + 1) begin
                sport_cnt_ff[k] <= 16'h0000;
            end
        end else if (in_reset) begin
            sport_tick <= {NUM_SPORTS{1'b0}};
            for (k = 0; k < NUM_SPORTS; k = k + 1) begin
                sport_cnt_ff[k] <= 16'h0000;
            end
        end else begin
            sport_tick <= {NUM_SPORTS{1'b0}};
            if (core_tick) begin
                for (k = 0; k < NUM_SPORTS; k = k + 1) begin
                    if (sport_cnt_ff[k] >= safe_ratio(sport_div_ff[k]) - 16'h0001) begin
                        sport_cnt_ff[k] <= 16'h0000;
                        sport_tick[k]   <= 1'b1;
                    end else begin
                        sport_cnt_ff[k] <= sport_cnt_ff[k] + 16'h0001;
                    end
                end
            end
        end
    end

    // Read decode; unmapped addresses answer with an error and zero data
    always @* begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr)
            `ADDR_PMC: begin
                rd_mux[`PMC_MULT_LSB +: `PMC_MULT_W] = mult_ff;
                rd_mux[`PMC_DIV_LSB +: `PMC_DIV_W]   = div_code_ff;
                rd_mux[`PMC_HALVE_BIT]               = halve_ff;
            end
            `ADDR_SPI_BAUD: rd_mux[15:0] = spi_baud_ff;
            `ADDR_STATUS: begin
                rd_mux[0]    = core_reset_n;
                rd_mux[2:1]  = strap_ff;
                rd_mux[9:4]  = eff_mult;
                rd_mux[14:10] = eff_div;
            end
            `ADDR_VCO_RATIO: rd_mux[15:0] = {vco_mult, core_div};
            default: begin
                addr_ok = sport_hit;
                for (i = 0; i < NUM_SPORTS; i = i + 1) begin
                    if (sport_hit && sport_idx == i[11:0]) begin
                        rd_mux[15:0] = sport_div_ff[i];
                    end
                end
            end
        endcase
    end

    // Read word is taken at setup so it stands unchanged through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end else if (rd_en) begin
            prdata <= prdata;
        end
    end

endmodule // core_clock_pll_reset_control

/* File: test/clock_source_model.sv */
// Oscillator and reset source model driving reset pin, straps and core tick
`timescale 1ns/1ps
module clock_source_model (
    input  logic       pclk,
    input  logic       presetn,
    input  logic       hold,
    input  logic [1:0] strap,
    input  logic       slow,
    output logic       reset_in_n,
    output logic [1:0] ratio_select_pins,
    output logic       core_tick
);
    logic [4:0] low_ff;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_ff <= 5'h00;
            reset_in_n <= 1'b0;
            ratio_select_pins <= 2'h0;
            core_tick <= 1'b0;
        end else begin
            low_ff <= hold ? 5'h00 : (low_ff == 5'h18 ? low_ff : low_ff + 5'h01);
            // Long low time keeps straps settled well before the pin rises
            reset_in_n <= !hold && low_ff == 5'h18;
            if (hold) ratio_select_pins <= strap;
            core_tick <= !slow || !core_tick;
        end
    end
endmodule // clock_source_model

/* File: test/core_clock_pll_reset_control_assertions.sv */
// Concurrent checks on strap ratio, derived ticks and core reset release
`timescale 1ns/1ps
`include "clock_control_defines.vh"
module core_clock_pll_reset_control_assertions #(
    parameter NUM_SPORTS     = 2,
    parameter RELEASE_CYCLES = 4096
) (
    input logic                  pclk,
    input logic                  presetn,
    input logic                  reset_in_n,
    input logic [1:0]            ratio_select_pins,
    input logic                  core_tick,
    input logic                  core_reset_n,
    input logic [7:0]            vco_mult,
    input logic [7:0]            core_div,
    input logic [1:0]            mem_per_core,
    input logic [NUM_SPORTS-1:0] sport_tick,
    input logic                  spi_tick
);
    // Sync slip of the pin allows the release at its nominal edge or one edge later
    localparam int RLO = RELEASE_CYCLES + 3;
    localparam int RHI = RELEASE_CYCLES + 4;
    logic [15:0] hi_ff;
    logic [5:0]  strap_mult;
    assign strap_mult = ratio_select_pins == 2'h1 ? `STRAP_MULT_01 :
                        ratio_select_pins == 2'h2 ? `STRAP_MULT_10 :
                        ratio_select_pins == 2'h3 ? `STRAP_MULT_11 : `STRAP_MULT_00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_ff <= 16'h0000;
        else if (!reset_in_n) hi_ff <= 16'h0000;
        else if (hi_ff != 16'hFFFF) hi_ff <= hi_ff + 16'h0001;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_strap_held;
        (!core_reset_n && $stable(ratio_select_pins))[*4];
    endsequence
    sequence s_pin_low;
        !reset_in_n [*3];
    endsequence
    property p_strap; s_strap_held |-> vco_mult == {1'b0, strap_mult, 1'b0}; endproperty
    property p_div_rst; (!core_reset_n)[*3] |-> core_div == 8'h02; endproperty
    property p_div_run;
        core_reset_n && $past(core_reset_n) |-> core_div inside {8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    endproperty
    property p_mem; $past(presetn) |-> mem_per_core == `MEM_PER_CORE; endproperty
    property p_spi; spi_tick |-> $past(core_tick); endproperty
    property p_sport; |sport_tick |-> $past(core_tick); endproperty
    property p_quiet; (!core_reset_n)[*2] |-> sport_tick == '0 && !spi_tick; endproperty
    property p_late; reset_in_n && hi_ff == RHI |-> core_reset_n; endproperty
    property p_early; $rose(core_reset_n) |-> hi_ff >= RLO; endproperty
    property p_drop; s_pin_low |=> !core_reset_n; endproperty
    a_strap: assert property (p_strap) else $error("strap ratio wrong");
    a_div_rst: assert property (p_div_rst) else $error("reset divider wrong");
    a_div_run: assert property (p_div_run) else $error("run divider wrong");
    a_mem: assert property (p_mem) else $error("memory ratio wrong");
    a_spi: assert property (p_spi) else $error("spi tick uncaused");
    a_sport: assert property (p_sport) else $error("port tick uncaused");
    a_quiet: assert property (p_quiet) else $error("tick in reset");
    a_late: assert property (p_late) else $error("release late");
    a_early: assert property (p_early) else $error("release early");
    a_drop: assert property (p_drop) else $error("core not reset");
endmodule // core_clock_pll_reset_control_assertions
bind core_clock_pll_reset_control core_clock_pll_reset_control_assertions #(
    .NUM_SPORTS(NUM_SPORTS), .RELEASE_CYCLES(RELEASE_CYCLES)) i_chk (
    .pclk(pclk), .presetn(presetn), .reset_in_n(reset_in_n),
    .ratio_select_pins(ratio_select_pins), .core_tick(core_tick),
    .core_reset_n(core_reset_n), .vco_mult(vco_mult), .core_div(core_div),
    .mem_per_core(mem_per_core), .sport_tick(sport_tick), .spi_tick(spi_tick));

/* File: test/core_clock_pll_reset_control_tb.sv */
// Testbench for the core clock ratio and core reset release block
`timescale 1ns/1ps
`include "clock_control_defines.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module core_clock_pll_reset_control_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hold, slow;
    logic        reset_in_n, core_tick, core_reset_n, spi_tick, err;
    logic [1:0]  strap, ratio_select_pins, mem_per_core, sport_tick;
    logic [7:0]  vco_mult, core_div;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          fail_count, checks, n_spi, n_s0, n_s1;
    core_clock_pll_reset_control #(.RELEASE_CYCLES(16)) i_core_clock_pll_reset_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_in_n(reset_in_n), .ratio_select_pins(ratio_select_pins), .core_tick(core_tick),
        .core_reset_n(core_reset_n), .vco_mult(vco_mult), .core_div(core_div),
        .mem_per_core(mem_per_core), .sport_tick(sport_tick), .spi_tick(spi_tick));
    clock_source_model i_clock_source_model (.pclk(pclk), .presetn(presetn), .hold(hold),
        .strap(strap), .slow(slow), .reset_in_n(reset_in_n),
        .ratio_select_pins(ratio_select_pins), .core_tick(core_tick));
    function automatic logic [5:0] mult_of(input logic [1:0] s);
        return s == 2'h1 ? `STRAP_MULT_01 : s == 2'h2 ? `STRAP_MULT_10 :
               s == 2'h3 ? `STRAP_MULT_11 : `STRAP_MULT_00;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        `CHK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHK(rd, exp)
    endtask
    task automatic wait_rel();
        int i;
        i = 0;
        while (core_reset_n !== 1'b1 && i < 100) begin
            @(negedge pclk);
            i++;
        end
        `CHK(core_reset_n, 1'b1)
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, slow, strap, paddr, pwdata} = '0;
        hold = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(mem_per_core, `MEM_PER_CORE)
        for (int s = 0; s < 4; s++) begin
            strap <= s[1:0];
            hold <= 1'b1;
            repeat (8) @(posedge pclk);
            rd_chk(`ADDR_VCO_RATIO, {17'h0, mult_of(s[1:0]), 1'b0, 8'h02});
            rd_chk(`ADDR_STATUS, {17'h0, 5'h01, mult_of(s[1:0]), 1'b0, s[1:0], 1'b0});
            // Software write during core reset must not override the straps
            apb(1'b1, `ADDR_PMC, 32'h0000_01FF);
            hold <= 1'b0;
            wait_rel();
            rd_chk(`ADDR_PMC, {26'h0, mult_of(s[1:0])});
        end
        $display("test strap_reset done");
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, `ADDR_PMC, {23'h0, k[2], k[1:0], 6'h04});
            rd_chk(`ADDR_VCO_RATIO, {16'h0, 8'h08, 8'h04 << k[1:0] << k[2]});
        end
        $display("test ratio done");
        rd_chk(`ADDR_SPI_BAUD, 32'h4);
        rd_chk(`ADDR_SPORT_BASE, 32'h4);
        apb(1'b1, `ADDR_SPI_BAUD, 32'h3);
        apb(1'b1, `ADDR_SPORT_BASE, 32'h5);
        for (int sl = 0; sl < 2; sl++) begin
            slow <= sl[0];
            repeat (20) @(posedge pclk);
            {n_spi, n_s0, n_s1} = '0;
            repeat (60 * (sl + 1)) begin
                @(posedge pclk);
                n_spi += int'(spi_tick);
                n_s0 += int'(sport_tick[0]);
                n_s1 += int'(sport_tick[1]);
            end
            `CHK(n_spi, 20)
            `CHK(n_s0, 12)
            `CHK(n_s1, 15)
        end
        $display("test ticks done");
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        $display("test unmapped done");
        finish_test();
    end
endmodule // core_clock_pll_reset_control_tb
